// [sel_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - Select high means selected, low means deselected.
// - Serial exchange accepted only while select stays high.
// - Falling select edge resets the command state machine; it stays reset while select is low.
// - Select falling after completed write cycle starts self-timed programming if writes are enabled and no programming is busy.
// - While deselected, clock and data input ignored, output left undriven.
// - Master holds select low one microsecond; device clears its control state then.
// - Data input sampled on each rising serial clock edge while selected.
// - Serial output driven only while selected, otherwise undriven.
// - Reselect during programming shows low while busy, high when ready.
module serial_eeprom_select_control #(
   parameter int unsigned PROG_CYC = sel_ctrl_pkg::PROG_TIME_CYC
) (
   // System
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire logic                      clk_en,
   // Serial link
   input  wire logic                      serial_clk_in,
   input  wire logic                      sel_in,
   input  wire logic                      serial_data_in,
   output logic                           data_out,
   output logic                           data_out_en,
   // Status
   output logic                           busy,
   output logic                           write_enabled,
   output logic                           prog_start,
   output logic [sel_ctrl_pkg::ADDR_W-1:0] prog_addr,
   output logic [sel_ctrl_pkg::DATA_W-1:0] prog_data,
   output logic                           prog_all
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shifts bits on serial clock, control state cleared while deselected
   sel_ctrl_pkg::link_st_t                st_ff;
   logic [sel_ctrl_pkg::CNT_W-1:0]        cnt_ff;
   logic [sel_ctrl_pkg::OPC_W-1:0]        opc_ff;
   logic [sel_ctrl_pkg::ADDR_W-1:0]       addr_ff;
   logic [sel_ctrl_pkg::DATA_W-1:0]       dat_ff;
   logic                                  wr_done_ff;
   logic                                  wen_done_ff;
   logic                                  wds_done_ff;
   logic [sel_ctrl_pkg::CNT_W-1:0]        nxt_cnt;

   assign nxt_cnt = cnt_ff + 5'h01;

   // Select low clears state, count and completion flags; rising select starts fresh
   always_ff @(posedge serial_clk_in or negedge sel_in) begin
      if (!sel_in) begin
         st_ff       <= sel_ctrl_pkg::ST_START;
         cnt_ff      <= '0;
         wr_done_ff  <= 1'b0;
         wen_done_ff <= 1'b0;
         wds_done_ff <= 1'b0;
      end else begin
         case (st_ff)
            sel_ctrl_pkg::ST_START: begin
               if (serial_data_in) begin
                  st_ff  <= sel_ctrl_pkg::ST_HDR;
                  cnt_ff <= 5'h01;
               end
            end
            sel_ctrl_pkg::ST_HDR: begin
               cnt_ff <= nxt_cnt;
               if (nxt_cnt == 5'(sel_ctrl_pkg::CMD_BITS)) begin
                  st_ff <= sel_ctrl_pkg::ST_DONE;
                  if (opc_ff == sel_ctrl_pkg::OPC_WRITE) begin
                     st_ff  <= sel_ctrl_pkg::ST_DATA;
                     cnt_ff <= '0;
                  end else if (opc_ff == sel_ctrl_pkg::OPC_ERASE) begin
                     wr_done_ff <= 1'b1;
                  end else if (opc_ff == sel_ctrl_pkg::OPC_EXT) begin
                     case (addr_ff[sel_ctrl_pkg::ADDR_W-2 -: 2])
                        sel_ctrl_pkg::EXT_WRALL: begin
                           st_ff  <= sel_ctrl_pkg::ST_DATA;
                           cnt_ff <= '0;
                        end
                        sel_ctrl_pkg::EXT_ERAL: wr_done_ff  <= 1'b1;
                        sel_ctrl_pkg::EXT_WEN:  wen_done_ff <= 1'b1;
                        default:                wds_done_ff <= 1'b1;
                     endcase
                  end
               end
            end
            sel_ctrl_pkg::ST_DATA: begin
               cnt_ff <= nxt_cnt;
               if (nxt_cnt == 5'(sel_ctrl_pkg::DATA_W)) begin
                  st_ff      <= sel_ctrl_pkg::ST_DONE;
                  wr_done_ff <= 1'b1;
               end
            end
            sel_ctrl_pkg::ST_DONE: begin
               // Extra clocks after a write abort programming
               wr_done_ff <= 1'b0;
            end
            default: st_ff <= sel_ctrl_pkg::ST_START;
         endcase
      end
   end

   // Command words keep their value after select falls, so the system side
   // can copy them; they are cleared on every idle clock before a start bit
   always_ff @(posedge serial_clk_in) begin
      if (sel_in) begin
         case (st_ff)
            sel_ctrl_pkg::ST_START: begin
               opc_ff  <= '0;
               addr_ff <= '0;
               dat_ff  <= '0;
            end
            sel_ctrl_pkg::ST_HDR: begin
               if (cnt_ff <= 5'(sel_ctrl_pkg::OPC_W)) begin
                  opc_ff <= {opc_ff[0], serial_data_in};
               end else begin
                  addr_ff <= {addr_ff[sel_ctrl_pkg::ADDR_W-2:0], serial_data_in};
               end
            end
            sel_ctrl_pkg::ST_DATA: begin
               dat_ff <= {dat_ff[sel_ctrl_pkg::DATA_W-2:0], serial_data_in};
            end
            default: begin
               opc_ff <= opc_ff;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain: synchronisers
   logic [2:0] sel_sync_ff;
   logic [1:0] wr_sync_ff;
   logic [1:0] wen_sync_ff;
   logic [1:0] wds_sync_ff;
   logic       wr_seen_ff;
   logic       wen_seen_ff;
   logic       wds_seen_ff;
   logic       sel_s;
   logic       sel_fall;

   assign sel_s    = sel_sync_ff[1];
   assign sel_fall = sel_sync_ff[2] & ~sel_sync_ff[1];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sel_sync_ff <= '0;
         wr_sync_ff  <= '0;
         wen_sync_ff <= '0;
         wds_sync_ff <= '0;
      end else if (clk_en) begin
         sel_sync_ff <= {sel_sync_ff[1:0], sel_in};
         wr_sync_ff  <= {wr_sync_ff[0], wr_done_ff};
         wen_sync_ff <= {wen_sync_ff[0], wen_done_ff};
         wds_sync_ff <= {wds_sync_ff[0], wds_done_ff};
      end
   end

   // Latch completion levels while selected; held on the select-fall cycle, dropped after
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_seen_ff  <= 1'b0;
         wen_seen_ff <= 1'b0;
         wds_seen_ff <= 1'b0;
      end else if (clk_en) begin
         if (sel_s) begin
            wr_seen_ff  <= wr_sync_ff[1];
            wen_seen_ff <= wen_sync_ff[1];
            wds_seen_ff <= wds_sync_ff[1];
         end else if (!sel_fall) begin
            wr_seen_ff  <= 1'b0;
            wen_seen_ff <= 1'b0;
            wds_seen_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write enable latch and programming timer
   logic        wen_ff;
   logic        busy_ff;
   logic        start_ff;
   logic [31:0] prog_cnt_ff;
   logic [sel_ctrl_pkg::ADDR_W-1:0] paddr_ff;
   logic [sel_ctrl_pkg::DATA_W-1:0] pdata_ff;
   logic        pall_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wen_ff <= 1'b0;
      end else if (clk_en && sel_fall) begin
         if (wen_seen_ff) begin
            wen_ff <= 1'b1;
         end else if (wds_seen_ff) begin
            wen_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_ff     <= 1'b0;
         start_ff    <= 1'b0;
         prog_cnt_ff <= '0;
      end else if (clk_en) begin
         start_ff <= 1'b0;
         if (busy_ff) begin
            if (prog_cnt_ff == PROG_CYC - 1) begin
               busy_ff <= 1'b0;
            end else begin
               prog_cnt_ff <= prog_cnt_ff + 32'h1;
            end
         end else if (sel_fall && wr_seen_ff && wen_ff) begin
            busy_ff     <= 1'b1;
            start_ff    <= 1'b1;
            prog_cnt_ff <= '0;
         end
      end
   end

   // Captured command words are stable once select falls
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         paddr_ff <= '0;
         pdata_ff <= '0;
         pall_ff  <= 1'b0;
      end else if (clk_en && sel_fall && wr_seen_ff && wen_ff && !busy_ff) begin
         paddr_ff <= addr_ff;
         pdata_ff <= (opc_ff == sel_ctrl_pkg::OPC_ERASE || opc_ff == sel_ctrl_pkg::OPC_EXT
                      && addr_ff[sel_ctrl_pkg::ADDR_W-1 -: 2] == sel_ctrl_pkg::EXT_ERAL)
                     ? '1 : dat_ff;
         pall_ff  <= (opc_ff == sel_ctrl_pkg::OPC_EXT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status output while selected
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_out    <= 1'b0;
         data_out_en <= 1'b0;
      end else if (clk_en) begin
         data_out_en <= sel_s;
         data_out    <= sel_s & ~busy_ff;
      end
   end

   assign busy          = busy_ff;
   assign write_enabled = wen_ff;
   assign prog_start    = start_ff;
   assign prog_addr     = paddr_ff;
   assign prog_data     = pdata_ff;
   assign prog_all      = pall_ff;

endmodule // serial_eeprom_select_control

// [sel_ctrl_pkg.sv]
package sel_ctrl_pkg;

   // Timing
   localparam int unsigned SYS_PERIOD_NS   = 40;
   localparam int unsigned DESEL_MIN_NS    = 1000;
   localparam int unsigned DESEL_MIN_CYC   = (DESEL_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int unsigned PROG_TIME_MS    = 15;
   localparam int unsigned PROG_TIME_CYC   = (PROG_TIME_MS * 1000000) / SYS_PERIOD_NS;

   // Command frame layout
   localparam int unsigned OPC_W           = 2;
   localparam int unsigned ADDR_W          = 6;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned CMD_BITS        = 1 + OPC_W + ADDR_W;
   localparam int unsigned WR_BITS         = CMD_BITS + DATA_W;
   localparam int unsigned CNT_W           = 5;

   // Opcodes
   localparam logic [1:0]  OPC_EXT         = 2'h0;
   localparam logic [1:0]  OPC_WRITE       = 2'h1;
   localparam logic [1:0]  OPC_READ        = 2'h2;
   localparam logic [1:0]  OPC_ERASE       = 2'h3;
   localparam logic [1:0]  EXT_WDS         = 2'h0;
   localparam logic [1:0]  EXT_WRALL       = 2'h1;
   localparam logic [1:0]  EXT_ERAL        = 2'h2;
   localparam logic [1:0]  EXT_WEN         = 2'h3;

   typedef enum logic [2:0] {
      ST_START,
      ST_HDR,
      ST_DATA,
      ST_DONE
   } link_st_t;

endpackage

// [sel_ctrl_sva.sv]
`timescale 1ns/1ps
module sel_ctrl_sva #(
   parameter int unsigned PROG_CYC = 300
) (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   // Link and status
   input wire logic sel_in,
   input wire logic data_out,
   input wire logic data_out_en,
   input wire logic busy,
   input wire logic write_enabled,
   input wire logic prog_start
);
   logic [31:0] busy_cnt_ff;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Busy length counter
   always_ff @(posedge clk_sys) begin
      busy_cnt_ff <= (rst || !busy) ? 32'h0 : busy_cnt_ff + 32'h1;
   end
   ////////////////////////////////////////////////////////////////
   a_en_when_sel: assert property (sel_in [*5] |-> data_out_en)
      else $error("output not driven while selected");
   a_en_off_desel: assert property ((!sel_in) [*5] |-> !data_out_en)
      else $error("output driven while deselected");
   a_start_after_fall: assert property (prog_start |-> !sel_in && !$past(sel_in, 3))
      else $error("programming start without select low");
   a_start_sets_busy: assert property (prog_start |=> busy)
      else $error("busy missing after start");
   a_start_needs_wen: assert property (prog_start |-> $past(write_enabled))
      else $error("start without write enable");
   a_busy_length: assert property ($fell(busy) |-> busy_cnt_ff == PROG_CYC)
      else $error("busy length wrong");
   a_no_restart: assert property ($past(busy) |-> !prog_start)
      else $error("start while busy");
   a_status_busy: assert property ((busy && data_out_en) [*2] |-> !data_out)
      else $error("status not low while busy");
   a_status_ready: assert property ((!busy && data_out_en) [*3] |-> data_out)
      else $error("status not high when ready");
   c_start: cover property (prog_start);
   c_poll_busy: cover property (busy && data_out_en);
   c_done: cover property ($fell(busy));
endmodule // sel_ctrl_sva

bind serial_eeprom_select_control sel_ctrl_sva #(.PROG_CYC(PROG_CYC)) i_sel_ctrl_sva (
   .clk_sys(clk_sys), .rst(rst), .sel_in(sel_in), .data_out(data_out),
   .data_out_en(data_out_en), .busy(busy), .write_enabled(write_enabled),
   .prog_start(prog_start));

// [serial_eeprom_select_control_tb_top.sv]
`timescale 1ns/1ps
module serial_eeprom_select_control_tb_top;
   localparam int unsigned PROG_CYC = 300;
   localparam logic [24:0] WR = {1'b1, sel_ctrl_pkg::OPC_WRITE, 6'h2a, 16'ha5c3};
   logic                              clk_sys = 1'b0;
   logic                              rst = 1'b1;
   logic                              clk_en = 1'b1;
   logic                              sel_in, serial_clk_in, serial_data_in;
   logic                              data_out, data_out_en, busy, write_enabled;
   logic                              prog_start, prog_all;
   logic [sel_ctrl_pkg::ADDR_W-1:0]   prog_addr;
   logic [sel_ctrl_pkg::DATA_W-1:0]   prog_data;
   int                                errors = 0;
   int                                checks = 0;
   int                                starts = 0;
   int                                cycles = 0;
   always #20 clk_sys = ~clk_sys;
   serial_eeprom_select_control #(.PROG_CYC(PROG_CYC)) i_serial_eeprom_select_control (
      .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .serial_clk_in(serial_clk_in),
      .sel_in(sel_in), .serial_data_in(serial_data_in), .data_out(data_out),
      .data_out_en(data_out_en), .busy(busy), .write_enabled(write_enabled),
      .prog_start(prog_start), .prog_addr(prog_addr), .prog_data(prog_data),
      .prog_all(prog_all));
   serial_host_model i_serial_host_model (
      .sel_in(sel_in), .serial_clk_in(serial_clk_in), .serial_data_in(serial_data_in));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (prog_start === 1'b1) starts++;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end
   // One frame, then count programming starts
   task automatic frame(input logic [24:0] bits, input int n, input int exp, input bit low);
      int s0;
      s0 = starts;
      i_serial_host_model.send(bits, n, low);
      repeat (10) @(negedge clk_sys);
      check("prog_start count", starts - s0, exp);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_sys);
      check("busy", busy, 1'b0);
   endtask
   task automatic poll(input logic [1:0] exp);
      repeat (sel_ctrl_pkg::DESEL_MIN_CYC) @(negedge clk_sys);
      i_serial_host_model.select(1'b1);
      repeat (6) @(negedge clk_sys);
      check("status", {data_out_en, data_out}, exp);
      i_serial_host_model.select(1'b0);
      repeat (6) @(negedge clk_sys);
      check("out enable", data_out_en, 1'b0);
   endtask
   task automatic t_refused();
      frame(WR, 25, 0, 1'b0);
      check("write_enabled", write_enabled, 1'b0);
      $display("test refused done");
   endtask
   task automatic t_write_poll();
      frame({16'h0, 1'b1, sel_ctrl_pkg::OPC_EXT, sel_ctrl_pkg::EXT_WEN, 4'h0}, 9, 0, 1'b0);
      check("write_enabled", write_enabled, 1'b1);
      frame(WR, 25, 1, 1'b0);
      check("prog_addr", prog_addr, 6'h2a);
      check("prog_data", prog_data, 16'ha5c3);
      poll(2'h2);
      frame(WR, 25, 0, 1'b0);
      wait_idle();
      poll(2'h3);
      frame(WR, 25, 0, 1'b1);
      $display("test write poll done");
   endtask
   task automatic t_prog(input logic [24:0] b, input int n, input logic all, input logic [15:0] d);
      frame(25'h5, 3, 0, 1'b0);
      frame(b, n, 1, 1'b0);
      check("prog_all", prog_all, all);
      check("prog_data", prog_data, d);
      wait_idle();
      $display("test program done");
   endtask
   initial begin
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      check("reset outs", {busy, data_out_en, write_enabled, prog_start}, 4'h0);
      t_refused();
      t_write_poll();
      t_prog({16'h0, 1'b1, sel_ctrl_pkg::OPC_ERASE, 6'h15}, 9, 1'b0, 16'hffff);
      t_prog({16'h0, 1'b1, sel_ctrl_pkg::OPC_EXT, sel_ctrl_pkg::EXT_ERAL, 4'h0}, 9, 1'b1, 16'hffff);
      t_prog({1'b1, sel_ctrl_pkg::OPC_EXT, sel_ctrl_pkg::EXT_WRALL, 4'h0, 16'h3c96}, 25, 1'b1,
         16'h3c96);
      frame({16'h0, 1'b1, sel_ctrl_pkg::OPC_EXT, sel_ctrl_pkg::EXT_WDS, 4'h0}, 9, 0, 1'b0);
      t_refused();
      give_verdict();
   end
endmodule // serial_eeprom_select_control_tb_top

// [serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
   // Serial link
   output logic sel_in,
   output logic serial_clk_in,
   output logic serial_data_in
);
   initial begin
      sel_in = 1'b0;
      serial_clk_in = 1'b0;
      serial_data_in = 1'b0;
   end
   // Deselect gap, then n bits MSB first
   task automatic send(input logic [24:0] bits, input int n, input bit hold_low);
      #1000;
      sel_in = !hold_low;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = bits[i];
         #62.5 serial_clk_in = 1'b1;
         #62.5 serial_clk_in = 1'b0;
      end
      sel_in = 1'b0;
      serial_data_in = ~serial_data_in;
   endtask
   // Select level for status polls
   task automatic select(input logic lvl);
      sel_in = lvl;
   endtask
endmodule // serial_host_model
